// *** verilog/plm_pkg.sv ***
// Notes on behaviour
// RL1: Input 09h routed into the third XOR gate.
// RL2: Per-input invert bit complements selected source.
// RL3: Input 0Dh drives flop one clear, low-active.
// RL4: Input 0Fh drives flop two clock.
// RL5: Four bytes report pin levels, ascending order.
// RL6: Matrix select bytes reset to zero.
// RL7: Offsets ACh and ADh reserved, read zero.
// RL8: Source is a pin or another element.
// RL9: Flops capture on rising edge, clear asynchronously. Only q clears at once; the feedback copy q_raw clears on the next sys_clk edge.
package plm_pkg;

  localparam int unsigned NUM_PINS    = 32;
  localparam int unsigned NUM_ROUTED  = 8;
  localparam int unsigned NUM_SEL_REG = 4;
  localparam int unsigned NUM_ELEM    = 7;

  // Register offsets
  localparam logic [7:0] OFS_SEL5  = 8'hA4;
  localparam logic [7:0] OFS_SEL6  = 8'hA5;
  localparam logic [7:0] OFS_SEL7  = 8'hA6;
  localparam logic [7:0] OFS_SEL8  = 8'hA7;
  localparam logic [7:0] OFS_PIN1  = 8'hA8;
  localparam logic [7:0] OFS_PIN2  = 8'hA9;
  localparam logic [7:0] OFS_PIN3  = 8'hAA;
  localparam logic [7:0] OFS_PIN4  = 8'hAB;
  localparam logic [7:0] OFS_RSVD0 = 8'hAC;
  localparam logic [7:0] OFS_RSVD1 = 8'hAD;

  // Reset values
  localparam logic [7:0] RST_SEL  = 8'h00;
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_RD   = 8'h00;

  // Field positions inside a select byte
  localparam int unsigned FLD_EVEN_SEL_LSB = 0;
  localparam int unsigned FLD_EVEN_INV     = 3;
  localparam int unsigned FLD_ODD_SEL_LSB  = 4;
  localparam int unsigned FLD_ODD_INV      = 7;

  // Source select code for the routed pin
  localparam logic [2:0] SEL_PIN = 3'h0;

  // Routed input index = matrix input number minus 08h
  localparam int unsigned IDX_THIRD_XOR_GATE_A  = 0;
  localparam int unsigned IDX_THIRD_XOR_GATE_B  = 1;
  localparam int unsigned IDX_FF1_D   = 2;
  localparam int unsigned IDX_FF2_D   = 3;
  localparam int unsigned IDX_FF1_CLK = 4;
  localparam int unsigned IDX_FF1_CLR = 5;
  localparam int unsigned IDX_FF2_CLR = 6;
  localparam int unsigned IDX_FF2_CLK = 7;

  typedef struct packed {
    logic       invert;
    logic [2:0] sel;
  } plm_route_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } plm_cfg_req_t;

endpackage : plm_pkg

// *** verilog/plm_matrix_flop.sv ***
`timescale 1ns/1ps
module plm_matrix_flop (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic d,
  input  wire logic clk_src,
  input  wire logic clr_n,
  output logic      q,
  output logic      q_raw
);
  import plm_pkg::*;

  logic clk_prev_q;
  logic clk_prev_d;
  logic q_q;
  logic q_d;

  always_comb begin
    clk_prev_d = clk_src;
    q_d        = q_q;
    if (!clr_n) begin
      q_d = 1'b0; // [RL9]
    end else if (clk_src && !clk_prev_q) begin
      q_d = d; // [RL9]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
      q_q        <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
      q_q        <= q_d;
    end
  end

  // Clear masks the output at once, ahead of the register
  assign q     = q_q & clr_n; // [RL9]
  // Unmasked copy for feedback, avoids a combinational loop
  assign q_raw = q_q;

endmodule : plm_matrix_flop

// *** verilog/plm_matrix.sv ***
`timescale 1ns/1ps
module plm_matrix #(
  parameter int unsigned PINS = plm_pkg::NUM_PINS
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire plm_pkg::plm_cfg_req_t cfg_req,
  output logic [7:0]               cfg_rdata,
  output logic                     cfg_rvalid,
  input  wire logic [PINS-1:0]     programmable_pin,
  input  wire logic [7:0]          matrix_pin_src,
  input  wire logic [3:0]          lower_elem_out,
  output logic                     third_xor_gate,
  output logic                     flop1_q,
  output logic                     flop2_q
);
  import plm_pkg::*;

  // Pin synchronisers
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;
  logic [7:0]      src_meta_q;
  logic [7:0]      src_sync_q;

  // Configuration and read path
  logic [7:0] sel_q [NUM_SEL_REG];
  logic [7:0] sel_d [NUM_SEL_REG];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  // Matrix state
  logic                third_xor_gate_q;
  logic                third_xor_gate_d;
  logic [NUM_ROUTED-1:0] routed;
  logic [NUM_ELEM:1]   elem;
  logic                ff1_raw;
  logic                ff2_raw;
  logic                ff1_q;
  logic                ff2_q;

  function automatic plm_route_t route_field(input logic [7:0] cfg, input logic odd);
    plm_route_t r;
    if (odd) begin
      r.invert = cfg[FLD_ODD_INV];
      r.sel    = cfg[FLD_ODD_SEL_LSB +: 3];
    end else begin
      r.invert = cfg[FLD_EVEN_INV];
      r.sel    = cfg[FLD_EVEN_SEL_LSB +: 3];
    end
    return r;
  endfunction : route_field

  function automatic logic route_level(input plm_route_t r, input logic pin, input logic [NUM_ELEM:1] el);
    logic src;
    src = (r.sel == SEL_PIN) ? pin : el[r.sel]; // [RL8]
    return src ^ r.invert; // [RL2]
  endfunction : route_level

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      src_meta_q <= '0;
      src_sync_q <= '0;
    end else begin
      pin_meta_q <= programmable_pin;
      pin_sync_q <= pin_meta_q;
      src_meta_q <= matrix_pin_src;
      src_sync_q <= src_meta_q;
    end
  end

  // Element outputs seen by select codes 1..7
  always_comb begin
    elem[4:1] = lower_elem_out;
    elem[5]   = third_xor_gate_q;
    elem[6]   = ff1_raw;
    elem[7]   = ff2_raw;
  end

  // Routed inputs 08h..0Fh, two per select byte
  always_comb begin
    for (int i = 0; i < NUM_ROUTED; i++) begin
      routed[i] = route_level(route_field(sel_q[i / 2], i[0]), src_sync_q[i], elem); // [RL2]
    end
  end

  always_comb begin
    third_xor_gate_d = routed[IDX_THIRD_XOR_GATE_A] ^ routed[IDX_THIRD_XOR_GATE_B]; // [RL1]
  end

  plm_matrix_flop u_flop1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (routed[IDX_FF1_D]),
    .clk_src (routed[IDX_FF1_CLK]),
    .clr_n   (routed[IDX_FF1_CLR]), // [RL3]
    .q       (ff1_q),
    .q_raw   (ff1_raw)
  );

  plm_matrix_flop u_flop2 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (routed[IDX_FF2_D]),
    .clk_src (routed[IDX_FF2_CLK]), // [RL4]
    .clr_n   (routed[IDX_FF2_CLR]),
    .q       (ff2_q),
    .q_raw   (ff2_raw)
  );

  // Register writes
  always_comb begin
    for (int i = 0; i < NUM_SEL_REG; i++) begin
      sel_d[i] = sel_q[i];
    end
    if (cfg_req.wr && in_range(cfg_req.addr, OFS_SEL5, OFS_SEL8)) begin
      sel_d[2'(cfg_req.addr - OFS_SEL5)] = cfg_req.wdata;
    end
  end

  // Register reads, one cycle after the strobe
  always_comb begin
    rvalid_d = cfg_req.rd;
    rdata_d  = rdata_q;
    if (cfg_req.rd) begin
      unique case (cfg_req.addr)
        OFS_SEL5:  rdata_d = sel_q[0];
        OFS_SEL6:  rdata_d = sel_q[1];
        OFS_SEL7:  rdata_d = sel_q[2];
        OFS_SEL8:  rdata_d = sel_q[3];
        OFS_PIN1:  rdata_d = pin_sync_q[7:0]; // [RL5]
        OFS_PIN2:  rdata_d = pin_sync_q[15:8]; // [RL5]
        OFS_PIN3:  rdata_d = pin_sync_q[23:16]; // [RL5]
        OFS_PIN4:  rdata_d = pin_sync_q[31:24]; // [RL5]
        OFS_RSVD0: rdata_d = RST_RSVD; // [RL7]
        OFS_RSVD1: rdata_d = RST_RSVD; // [RL7]
        default:   rdata_d = RST_RD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SEL_REG; i++) begin
        sel_q[i] <= RST_SEL; // [RL6]
      end
      rdata_q  <= RST_RD;
      rvalid_q <= 1'b0;
      third_xor_gate_q   <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_SEL_REG; i++) begin
        sel_q[i] <= sel_d[i];
      end
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      third_xor_gate_q   <= third_xor_gate_d;
    end
  end

  assign cfg_rdata      = rdata_q;
  assign cfg_rvalid     = rvalid_q;
  assign third_xor_gate = third_xor_gate_q;
  assign flop1_q        = ff1_q;
  assign flop2_q        = ff2_q;

endmodule : plm_matrix

// *** tb/plm_chk.sv ***
`timescale 1ns/1ps
module plm_chk
  import plm_pkg::*;
#(
  parameter int unsigned PINS = 32
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire plm_pkg::plm_cfg_req_t cfg_req,
  input wire logic [7:0]            cfg_rdata,
  input wire logic                  cfg_rvalid,
  input wire logic [PINS-1:0]       programmable_pin,
  input wire logic [7:0]            matrix_pin_src,
  input wire logic [3:0]            lower_elem_out,
  input wire logic                  third_xor_gate,
  input wire logic                  flop1_q,
  input wire logic                  flop2_q
);
  logic [7:0] sh_q [4];
  logic [7:0] sh_d [4];
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] r;
  logic [7:0] ok;

  always_comb begin
    sh_d = sh_q;
    if (cfg_req.wr && cfg_req.addr[7:2] == 6'h29) begin
      sh_d[cfg_req.addr[1:0]] = cfg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_q <= '{default: 8'h00};
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else begin
      sh_q <= sh_d;
      s1_q <= matrix_pin_src;
      s2_q <= s1_q;
    end
  end

  // Routed level per input, valid for codes 0..4
  always_comb begin : route
    logic [3:0] f;
    f = 4'h0;
    for (int k = 0; k < 8; k++) begin
      f = k[0] ? sh_q[k/2][7:4] : sh_q[k/2][3:0];
      ok[k] = f[2:0] < 3'h5;
      r[k] = (f[2:0] == 3'h0 ? s2_q[k] : lower_elem_out[f[1:0] - 2'h1]) ^ f[3];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    $stable(programmable_pin)[*3];
  endsequence
  sequence s_rise2;
    ok[7] && ok[3] && ok[6] && $rose(r[7]) && r[6];
  endsequence

  AST_RVALID: assert property (cfg_req.rd |=> cfg_rvalid)
    else $error("read without answer");
  AST_NORVALID: assert property (!cfg_req.rd |=> !cfg_rvalid)
    else $error("answer without read");
  AST_RSVD: assert property (cfg_req.rd && cfg_req.addr[7:1] == 7'h56 |=> cfg_rdata == 8'h00)
    else $error("reserved byte not zero");
  AST_PIN: assert property (s_quiet ##0 (cfg_req.rd && cfg_req.addr == OFS_PIN1)
    |=> cfg_rdata == $past(programmable_pin[7:0]))
    else $error("pin byte mismatch");
  AST_XOR: assert property (ok[0] && ok[1] |=> third_xor_gate == $past(r[0] ^ r[1]))
    else $error("xor output mismatch");
  AST_CLR1: assert property (ok[5] && !r[5] |-> !flop1_q)
    else $error("flop one not cleared");
  AST_CLR2: assert property (ok[6] && !r[6] |-> !flop2_q)
    else $error("flop two not cleared");
  AST_CLK2: assert property (s_rise2 ##1 ($stable(r[3]) && r[6] && ok[3])[*2] |-> flop2_q == r[3])
    else $error("flop two missed capture");
endmodule : plm_chk

// *** tb/pin_logic_matrix_and_readback_bench.sv ***
`timescale 1ns/1ps
module pin_logic_matrix_and_readback_bench;
  import plm_pkg::*;
  logic         sys_clk  = 1'b0;
  logic         rst      = 1'b1;
  plm_cfg_req_t cfg_req  = '0;
  logic [7:0]   cfg_rdata;
  logic         cfg_rvalid;
  logic [31:0]  pins     = '0;
  logic [7:0]   src      = '0;
  logic [3:0]   lower    = '0;
  logic [31:0]  seed     = 32'he7e2_6405;
  logic [7:0]   sel_m [4] = '{default: 8'h00};
  logic         xor_o;
  logic [7:0]   src_h [$] = '{8'h00, 8'h00, 8'h00};
  int           n_errors = 0;
  int           checks   = 0;

  plm_matrix dut (.sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .programmable_pin(pins), .matrix_pin_src(src), .lower_elem_out(lower),
    .third_xor_gate(xor_o), .flop1_q(), .flop2_q());

  initial forever #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nx

  // Routed level of input 08h+k from the select model, codes 0..4 only
  function automatic logic lvl(input int k, input logic [7:0] s);
    logic [3:0] f;
    f = 4'(sel_m[k / 2] >> (4 * (k % 2)));
    return (f[2:0] == 3'h0 ? s[k] : lower[f[1:0] - 2'h1]) ^ f[3];
  endfunction : lvl

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = 8'h00;
    @(negedge sys_clk);
    cfg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge sys_clk);
    cfg_req = '0;
    if (a[7:2] == 6'h29 && w) sel_m[a[1:0]] = d;
    if (a[7:2] == 6'h29) e = sel_m[a[1:0]];
    if (a[7:2] == 6'h2a) e = 8'(pins >> (8 * a[1:0]));
    if (!w) begin
      check("rvalid", {7'h00, cfg_rvalid}, 8'h01);
      check("rdata", cfg_rdata, e);
    end
  endtask : access

  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    for (int a = 'ha4; a < 'hb0; a++) access(1'b0, a[7:0], 8'h00);
    for (int i = 0; i < 80; i++) begin
      pins = nx();
      access(1'b1, 8'ha4 + 8'(i % 10), 8'(nx()) & (i[2] ? 8'hbb : 8'hcc));
      for (int j = 0; j < 20; j++) begin
        @(negedge sys_clk);
        if (j >= 3) check("xor", {7'h00, xor_o}, {7'h00, lvl(0, src_h[$-2]) ^ lvl(1, src_h[$-2])});
        src = 8'(nx());
        lower = 4'(nx());
        src_h.push_back(src);
        if (src_h.size() > 3) src_h.pop_front();
      end
      access(1'b0, 8'ha4 + 8'((i * 7) % 10), 8'h00);
    end
    // Mid-run reset must bring every select byte back to zero
    @(negedge sys_clk);
    rst = 1'b1;
    sel_m = '{default: 8'h00};
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    for (int a = 'ha4; a < 'ha8; a++) access(1'b0, a[7:0], 8'h00);
    summarize();
  end

  initial begin
    #200us;
    n_errors++;
    summarize();
  end
endmodule : pin_logic_matrix_and_readback_bench

bind plm_matrix plm_chk #(.PINS(PINS)) u_chk (.sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .programmable_pin(programmable_pin),
  .matrix_pin_src(matrix_pin_src), .lower_elem_out(lower_elem_out), .third_xor_gate(third_xor_gate),
  .flop1_q(flop1_q), .flop2_q(flop2_q));
